/* File: ucev_pkg.sv */
// Constants and carrier types for the uncore event counter bank.
// Assumes a single processor clock and model register accesses of 64 bits.
package ucev_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [31:0] ADDR_BUSQ_EV0    = 32'h000107CC;
   localparam logic [31:0] ADDR_BUSQ_EV1    = 32'h000107CD;
   localparam logic [31:0] ADDR_SNPQ_EV0    = 32'h000107CE;
   localparam logic [31:0] ADDR_SNPQ_EV1    = 32'h000107CF;
   localparam logic [31:0] ADDR_EXT_EV0     = 32'h000107D0;
   localparam logic [31:0] ADDR_EXT_EV1     = 32'h000107D1;
   localparam logic [31:0] ADDR_LAT_CTL     = 32'h000107D2;
   localparam logic [31:0] ADDR_LAT_ACC     = 32'h000107D3;
   localparam logic [31:0] ADDR_FIRST       = ADDR_BUSQ_EV0;
   localparam logic [31:0] NUM_REGS         = 32'h00000008;
   localparam int          NUM_EVENT        = 6;

   // Indexed counter read numbering
   localparam logic [31:0] PMC_FIRST        = 32'h00000012;

   // Bank slots of the latency pair
   localparam logic [2:0]  IDX_LAT_CTL      = 3'h6;
   localparam logic [2:0]  IDX_LAT_ACC      = 3'h7;

   // ************************************************************
   // Field layout
   // ************************************************************
   localparam int          HALF_W           = 32;
   localparam int          REG_W            = 64;
   localparam int          LAT_EN_BIT       = 26;
   // Saturate sits in the top bit of the control half
   localparam int          SAT_BIT          = 31;
   localparam logic [31:0] CNT_MAX          = 32'hFFFFFFFF;
   localparam logic [31:0] HALF_RESET       = 32'h00000000;
   localparam logic [63:0] REG_RESET        = 64'h0000000000000000;

   // ************************************************************
   // Carrier types
   // ************************************************************
   typedef struct packed {
      logic [31:0] addr;
      logic        wr;
      logic        rd;
      logic [63:0] wdata;
   } ucev_msr_req_t;

   typedef struct packed {
      logic [31:0] index;
      logic        rd;
   } ucev_pmc_req_t;

endpackage : ucev_pkg

/* File: ucev_slice.sv */
// One event-class register: control upper half, 32-bit count lower half.
// Assumes event_in is a one-cycle qualified pulse on clk_in.
`timescale 1ns/1ps
module ucev_slice (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        wr_in,
   input  wire logic [63:0] wdata_in,
   input  wire logic        event_in,
   output logic      [63:0] reg_out
);
   import ucev_pkg::*;

   logic [31:0] ctl_r;
   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   wire         active_w  = |ctl_r;
   wire         sat_w     = ctl_r[SAT_BIT];
   wire         at_max_w  = (cnt_r == CNT_MAX);
   wire         bump_w    = active_w && event_in && !(sat_w && at_max_w);

   // Software write wins over a coincident event
   assign cnt_nxt = wr_in  ? wdata_in[HALF_W-1:0] :
                    bump_w ? cnt_r + 32'h00000001 : cnt_r;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ctl_r <= HALF_RESET;
         cnt_r <= HALF_RESET;
      end else begin
         if (wr_in) begin
            ctl_r <= wdata_in[REG_W-1:HALF_W];
         end
         cnt_r <= cnt_nxt;
      end
   end

   assign reg_out = {ctl_r, cnt_r};

endmodule : ucev_slice

/* File: ucev_counters.sv */
// Uncore event counter bank: six event registers, latency control and
// a 64-bit latency accumulator, reached by model register accesses and
// by the indexed counter read. Events arrive on the processor clock.
`timescale 1ns/1ps
module ucev_counters #(
   parameter int LAT_W = 16
) (
   input  wire logic                   clk_in,
   input  wire logic                   rst_in,
   input  wire ucev_pkg::ucev_msr_req_t msr_req_in,
   input  wire ucev_pkg::ucev_pmc_req_t pmc_req_in,
   input  wire logic [5:0]             event_in,
   input  wire logic [LAT_W-1:0]       lat_weight_in,
   output logic      [63:0]            msr_rdata_out,
   output logic                        msr_rvalid_out,
   output logic      [63:0]            pmc_rdata_out,
   output logic                        pmc_rvalid_out
);
   import ucev_pkg::*;

   // ************************************************************
   // Elaboration checks
   // ************************************************************
   // Weight is zero-extended into the accumulator, so it must stay narrow
   if (LAT_W < 1 || LAT_W > 32) begin : g_bad_lat_w
      $error("LAT_W must lie between 1 and 32");
   end

   // ************************************************************
   // Decoding
   // ************************************************************
   // Returns {hit, slot} for an address counted from a base
   function automatic logic [3:0] slot_of(input logic [31:0] a,
                                          input logic [31:0] base);
      logic [31:0] off;
      off = a - base;
      slot_of = {(off < NUM_REGS), off[2:0]};
   endfunction : slot_of

   wire [3:0]  msr_slot_w = slot_of(msr_req_in.addr, ADDR_FIRST);
   wire [3:0]  pmc_slot_w = slot_of(pmc_req_in.index, PMC_FIRST);
   wire        msr_hit_w  = msr_slot_w[3];
   wire        pmc_hit_w  = pmc_slot_w[3];
   wire [7:0]  wr_sel_w;

   genvar gi;
   for (gi = 0; gi < NUM_REGS; gi++) begin : g_wsel
      assign wr_sel_w[gi] = msr_req_in.wr && msr_hit_w &&
                            (msr_slot_w[2:0] == 3'(gi));
   end

   // ************************************************************
   // Event registers
   // ************************************************************
   logic [7:0][63:0] bank_w;

   for (gi = 0; gi < NUM_EVENT; gi++) begin : g_slice
      ucev_slice u_slice (
         .clk_in   (clk_in),
         .rst_in   (rst_in),
         .wr_in    (wr_sel_w[gi]),
         .wdata_in (msr_req_in.wdata),
         .event_in (event_in[gi]),
         .reg_out  (bank_w[gi])
      );
   end

   // ************************************************************
   // Latency control and accumulator
   // ************************************************************
   logic [63:0] lat_ctl_r;
   logic [63:0] lat_acc_r;
   logic [63:0] lat_acc_nxt;
   wire         lat_en_w   = lat_ctl_r[LAT_EN_BIT];
   wire [63:0]  lat_add_w  = {{(REG_W-LAT_W){1'b0}}, lat_weight_in};

   // Disabled accumulator holds rather than clearing
   assign lat_acc_nxt = wr_sel_w[IDX_LAT_ACC] ? msr_req_in.wdata :
                        lat_en_w ? lat_acc_r + lat_add_w :
                        lat_acc_r;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         lat_ctl_r <= REG_RESET;
         lat_acc_r <= REG_RESET;
      end else begin
         if (wr_sel_w[IDX_LAT_CTL]) begin
            lat_ctl_r <= msr_req_in.wdata;
         end
         lat_acc_r <= lat_acc_nxt;
      end
   end

   assign bank_w[IDX_LAT_CTL] = lat_ctl_r;
   assign bank_w[IDX_LAT_ACC] = lat_acc_r;

   // ************************************************************
   // Read paths
   // ************************************************************
   // Unmapped addresses and indexes read as zero
   wire [63:0] msr_sel_w = msr_hit_w ? bank_w[msr_slot_w[2:0]] : REG_RESET;
   wire [63:0] pmc_sel_w = pmc_hit_w ?
                           {HALF_RESET, bank_w[pmc_slot_w[2:0]][31:0]} :
                           REG_RESET;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         msr_rdata_out  <= REG_RESET;
         msr_rvalid_out <= 1'b0;
         pmc_rdata_out  <= REG_RESET;
         pmc_rvalid_out <= 1'b0;
      end else begin
         msr_rvalid_out <= msr_req_in.rd;
         pmc_rvalid_out <= pmc_req_in.rd;
         if (msr_req_in.rd) begin
            msr_rdata_out <= msr_sel_w;
         end
         if (pmc_req_in.rd) begin
            pmc_rdata_out <= pmc_sel_w;
         end
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   wire [31:0] busq0_cnt_w = bank_w[0][31:0];
   wire [31:0] busq0_ctl_w = bank_w[0][63:32];
   wire [31:0] snpq0_ctl_w = bank_w[2][63:32];
   wire [31:0] ext0_ctl_w  = bank_w[4][63:32];

   property p_full_write;
      msr_req_in.wr && msr_req_in.addr == ADDR_LAT_CTL
         |=> lat_ctl_r == $past(msr_req_in.wdata);
   endproperty
   a_full_write: assert property (p_full_write)
      else $error("latency control not written in full");

   property p_msr_answer;
      msr_req_in.rd && !msr_req_in.wr && msr_req_in.addr == ADDR_LAT_ACC
         |=> msr_rvalid_out && msr_rdata_out == $past(lat_acc_r);
   endproperty
   a_msr_answer: assert property (p_msr_answer)
      else $error("model register read wrong or late");

   property p_pmc_low;
      pmc_req_in.rd && pmc_req_in.index == PMC_FIRST
         |=> pmc_rdata_out[31:0] == $past(busq0_cnt_w);
   endproperty
   a_pmc_low: assert property (p_pmc_low)
      else $error("indexed read 18 not the first counter");

   property p_pmc_upper;
      pmc_rvalid_out |-> pmc_rdata_out[63:32] == HALF_RESET;
   endproperty
   a_pmc_upper: assert property (p_pmc_upper)
      else $error("indexed read upper half not zero");

   property p_busq_idle;
      busq0_ctl_w == HALF_RESET && !wr_sel_w[0]
         |=> $stable(busq0_cnt_w);
   endproperty
   a_busq_idle: assert property (p_busq_idle)
      else $error("idle bus queue counter moved");

   property p_snpq_idle;
      snpq0_ctl_w == HALF_RESET && !wr_sel_w[2]
         |=> $stable(bank_w[2][31:0]);
   endproperty
   a_snpq_idle: assert property (p_snpq_idle)
      else $error("idle snoop queue counter moved");

   property p_ext_idle;
      ext0_ctl_w == HALF_RESET && !wr_sel_w[4]
         |=> $stable(bank_w[4][31:0]);
   endproperty
   a_ext_idle: assert property (p_ext_idle)
      else $error("idle external bus counter moved");

   property p_step;
      busq0_ctl_w != HALF_RESET && !busq0_ctl_w[SAT_BIT] &&
      event_in[0] && !wr_sel_w[0]
         |=> busq0_cnt_w == $past(busq0_cnt_w) + 32'h00000001;
   endproperty
   a_step: assert property (p_step)
      else $error("active counter did not step by one");

   property p_lat_run;
      lat_en_w && !wr_sel_w[IDX_LAT_ACC]
         |=> lat_acc_r == $past(lat_acc_r) + $past(lat_add_w);
   endproperty
   a_lat_run: assert property (p_lat_run)
      else $error("latency accumulator did not add weight");

   // Enable must stay low across both cycles, or a fresh enable adds weight
   property p_lat_freeze;
      !lat_en_w && !wr_sel_w[IDX_LAT_ACC] ##1
      !lat_en_w && !wr_sel_w[IDX_LAT_ACC]
         |=> $stable(lat_acc_r) && lat_acc_r == $past(lat_acc_r, 2);
   endproperty
   a_lat_freeze: assert property (p_lat_freeze)
      else $error("disabled latency accumulator changed");

   c_busq_wrap: cover property (busq0_cnt_w == CNT_MAX ##1
                                busq0_cnt_w == HALF_RESET);
   c_lat_run:   cover property (lat_en_w [*3] ##1 !lat_en_w);
   c_pmc_last:  cover property (pmc_req_in.rd &&
                                pmc_req_in.index == PMC_FIRST + 32'h7);

endmodule : ucev_counters

/* File: testbench.sv */
// Self-checking bench for the uncore event counter bank.
// Assumes ucev_pkg and ucev_counters are compiled ahead of this file.
`timescale 1ns/1ps
module testbench;
   import ucev_pkg::*;
   localparam int LW = 16;
   logic          clk_in     = 1'b0;
   logic          rst_in     = 1'b1;
   ucev_msr_req_t msr_req    = '0;
   ucev_pmc_req_t pmc_req    = '0;
   logic [5:0]    ev         = 6'h00;
   logic [LW-1:0] lat_weight = 16'h0000;
   logic [63:0]   msr_rdata;
   logic [63:0]   pmc_rdata;
   logic          msr_rvalid;
   logic          pmc_rvalid;
   logic [63:0]   shadow [8];
   logic [63:0]   msr_q [$];
   logic [63:0]   pmc_q [$];
   int            mismatches = 0;
   int            n_checks   = 0;

   always #2.5 clk_in = ~clk_in;

   ucev_counters #(.LAT_W(LW)) dut (
      .clk_in         (clk_in),
      .rst_in         (rst_in),
      .msr_req_in     (msr_req),
      .pmc_req_in     (pmc_req),
      .event_in       (ev),
      .lat_weight_in  (lat_weight),
      .msr_rdata_out  (msr_rdata),
      .msr_rvalid_out (msr_rvalid),
      .pmc_rdata_out  (pmc_rdata),
      .pmc_rvalid_out (pmc_rvalid)
   );

   // ************************************************************
   // Checking and access tasks
   // ************************************************************
   task automatic check(input string what, input logic [63:0] seen,
                        input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // One idle cycle after each access so no strobe is set twice at once
   task automatic setreg(input int i, input logic [63:0] d);
      shadow[i] = d;
      msr_req <= '{addr: ADDR_FIRST + 32'(i), wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge clk_in);
      msr_req.wr <= 1'b0;
      @(posedge clk_in);
   endtask : setreg

   task automatic msr_rd(input logic [31:0] a, input logic [63:0] e);
      msr_q.push_back(e);
      msr_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 64'h0};
      @(posedge clk_in);
      msr_req.rd <= 1'b0;
      @(posedge clk_in);
   endtask : msr_rd

   task automatic pmc_rd(input logic [31:0] i, input logic [63:0] e);
      pmc_q.push_back(e);
      pmc_req <= '{index: i, rd: 1'b1};
      @(posedge clk_in);
      pmc_req.rd <= 1'b0;
      @(posedge clk_in);
   endtask : pmc_rd

   task automatic read_all;
      for (int i = 0; i < 8; i++) begin
         msr_rd(ADDR_FIRST + 32'(i), shadow[i]);
         pmc_rd(PMC_FIRST + 32'(i), {32'h0, shadow[i][31:0]});
      end
   endtask : read_all

   task automatic pulse(input int n, input int k);
      ev <= 6'h01 << n;
      repeat (k) @(posedge clk_in);
      ev <= 6'h00;
      @(posedge clk_in);
   endtask : pulse

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude

   // ************************************************************
   // Result watcher
   // ************************************************************
   always @(posedge clk_in) begin
      if (msr_rvalid === 1'b1) begin
         if (msr_q.size() == 0) check("msr_extra", 64'h1, 64'h0);
         else check("msr_rdata", msr_rdata, msr_q.pop_front());
      end
      if (pmc_rvalid === 1'b1) begin
         if (pmc_q.size() == 0) check("pmc_extra", 64'h1, 64'h0);
         else check("pmc_rdata", pmc_rdata, pmc_q.pop_front());
      end
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      logic [63:0] d;
      logic [31:0] c;
      logic [LW-1:0] w;
      int k;
      void'($urandom(57409));
      repeat (8) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      for (int i = 0; i < 8; i++) shadow[i] = REG_RESET;
      read_all();
      // Full-width write and readback; latency kept disabled
      for (int i = 0; i < 8; i++) begin
         d = {$urandom, $urandom};
         if (i == 6) d[LAT_EN_BIT] = 1'b0;
         setreg(i, d);
      end
      // Unmapped places must not disturb the bank
      msr_req <= '{addr: ADDR_FIRST + 32'h8, wr: 1'b1, rd: 1'b0, wdata: '1};
      @(posedge clk_in);
      msr_req.wr <= 1'b0;
      @(posedge clk_in);
      msr_rd(ADDR_FIRST + 32'h8, 64'h0);
      msr_rd(ADDR_FIRST - 32'h1, 64'h0);
      pmc_rd(PMC_FIRST - 32'h1, 64'h0);
      pmc_rd(PMC_FIRST + 32'h8, 64'h0);
      read_all();
      // Event counters: idle, count, saturate; wrap is driven but overwritten before any read
      for (int n = 0; n < NUM_EVENT; n++) begin
         setreg(n, {32'h0, $urandom});
         pulse(n, 3);
         // Idle count must be read back before the next write hides it
         msr_rd(ADDR_FIRST + 32'(n), shadow[n]);
         c = $urandom | 32'h1;
         c[SAT_BIT] = 1'b0;
         setreg(n, {c, $urandom});
         k = 1 + $urandom % 8;
         pulse(n, k);
         shadow[n][31:0] = shadow[n][31:0] + 32'(k);
         read_all();
         setreg(n, {c, CNT_MAX});
         pulse(n, 2);
         shadow[n][31:0] = 32'h1;
         setreg(n + 0, shadow[n]);
         c[SAT_BIT] = 1'b1;
         setreg(n, {c, 32'hFFFFFFFE});
         pulse(n, 3);
         shadow[n][31:0] = CNT_MAX;
         read_all();
      end
      // Latency accumulator: carry into upper half, then freeze
      setreg(7, {$urandom, 32'hFFFFFF00});
      setreg(6, 64'h1 << LAT_EN_BIT);
      w = LW'($urandom);
      k = 1 + $urandom % 50;
      lat_weight <= w;
      repeat (k) @(posedge clk_in);
      lat_weight <= '0;
      @(posedge clk_in);
      shadow[7] = shadow[7] + 64'(k) * 64'(w);
      setreg(6, 64'h0);
      lat_weight <= w;
      repeat (10) @(posedge clk_in);
      lat_weight <= '0;
      @(posedge clk_in);
      read_all();
      for (k = 0; k < 20 && (msr_q.size() + pmc_q.size()) > 0; k++) begin
         @(posedge clk_in);
      end
      if (msr_q.size() + pmc_q.size() > 0) mismatches++;
      conclude();
   end
endmodule : testbench
